// ==== pkg/lsef_consts.svh ====
/*
 * constants of the lin status and error flag block: register offsets,
 * field positions, reset values and timing.
 * assumes: included by bare name from design files.
 */
`ifndef LSEF_CONSTS_SVH
`define LSEF_CONSTS_SVH

// ============================================================
// register byte offsets
`define LSEF_OFF_STATUS 8'h00
`define LSEF_OFF_CTRL1 8'h04
`define LSEF_OFF_CTRL2 8'h08
`define LSEF_OFF_DATA 8'h0c
`define LSEF_OFF_LINCTL 8'h10

// ============================================================
// lin_status fields
`define LSEF_SR_HDR_ERR 3
`define LSEF_SR_NOISE 2
`define LSEF_SR_FRM_ERR 1
`define LSEF_SR_PAR_ERR 0
`define LSEF_SR_RST 8'hc0

// ============================================================
// serial_control_one fields
`define LSEF_CR1_RX8 7
`define LSEF_CR1_PAR_CHK 2
`define LSEF_CR1_PS 1
`define LSEF_CR1_PAR_IRQ 0
`define LSEF_CR1_RST 8'h00

// ============================================================
// serial_control_two fields
`define LSEF_CR2_RX_IRQ 5
`define LSEF_CR2_RE 2
`define LSEF_CR2_RST 8'h00

// ============================================================
// lin control fields
`define LSEF_LC_LIN 0
`define LSEF_LC_SLV 1
`define LSEF_LC_HDM 2
`define LSEF_LC_SFS 3
`define LSEF_LC_HDF 4
`define LSEF_LC_RST 8'h00

// ============================================================
// timing
`define LSEF_CLK_MHZ 125
`define LSEF_HDR_MAX_US 1000
`define LSEF_HDR_MAX_CYC (`LSEF_HDR_MAX_US * `LSEF_CLK_MHZ)

`endif

// ==== pkg/lsef_pkg.sv ====
/*
 * types of the lin status and error flag block.
 * assumes: compiled before every design file.
 */
`default_nettype none

package lsef_pkg;

    // ============================================================
    // receiver events, one-cycle pulses except the data fields
    typedef struct packed {
        logic brk;
        logic synch_ok;
        logic synch_bad;
        logic char_done;
        logic [7:0] data;
        logic bit8;
        logic stop_bit;
        logic noise;
        logic overrun;
        logic id_done;
    } lsef_rx_evt_t;

    // ============================================================
    // header phase
    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SYNC,
        HS_IDENT
    } lsef_hdr_st_t;

endpackage : lsef_pkg

`default_nettype wire

// ==== design/lsef_hdr_timer.sv ====
/*
 * header timeout counter: runs from the detected break while the header
 * is being received and stops at the limit, raising expire every cycle it runs there.
 * assumes: start and run are synchronous to clk_i.
 */
`default_nettype none

module lsef_hdr_timer #(
    parameter int MAX_CYC = 1000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic run_i,
    output logic expire_o
);
    localparam int CW = $clog2(MAX_CYC + 1);
    localparam logic [CW-1:0] LIMIT = CW'(MAX_CYC - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    wire at_lim = (cnt_q == LIMIT);

    // ============================================================
    // counter restarted by the break
    assign cnt_d = start_i ? '0 : (run_i && !at_lim) ? cnt_q + 1'b1 : cnt_q;
    assign expire_o = run_i && !start_i && at_lim;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : lsef_hdr_timer

`default_nettype wire

// ==== design/lsef_flags.sv ====
/*
 * lin status and error flags with avalon-mm register slave.
 * assumes: receiver event pulses are synchronous to CLK_I;
 * bus master holds each request until waitrequest is low.
 */
`default_nettype none
`include "lsef_consts.svh"

// Function
// - status register resets to c0h, read only; header, noise, framing, parity error at bits 3..0.
// - corrupted synch field sets header error and locks synch-field state to 1.
// - timeout during header reception sets header error.
// - overrun on any header field sets header error.
// - outside a header, header error reports ordinary overrun.
// - header error with receive irq enable raises interrupt.
// - status access then data read clears header error, except while synch-field state is locked at 1.
// - lin master role: noise flag as in plain serial mode.
// - lin slave role: noise flag meaningless, not checked.
// - slave framing error only for dominant stop with some recessive bit.
// - slave break sets header detect flag, not framing error, when method is 0.
// - status access then data read clears framing error.
// - parity check enabled and receiving: bad identifier parity sets parity error.
// - status read then data access clears parity error; irq when enabled.
// - parity check enable bit 2 turns on identifier parity checking.
// - control one resets bits 6..0 to 0; bit 1 reserved in lin mode.
// - lin frames never get parity generated on transmission.

module lsef_flags
    import lsef_pkg::*;
#(
    parameter int HDR_MAX_CYC = `LSEF_HDR_MAX_CYC
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic [7:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    input wire lsef_rx_evt_t RX_EVT_I,
    input wire logic [3:0] TX_STAT_I,
    output logic IRQ_O,
    output logic PAR_ODD_O,
    output logic TX_PAR_GEN_O
);

    // ============================================================
    // identifier parity
    function automatic logic [1:0] id_par(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0};
    endfunction : id_par

    // ============================================================
    // state
    logic ack_q;
    logic [31:0] rdata_q;
    logic [3:0] hi_q;
    logic hdr_err_q;
    logic noise_q;
    logic frm_err_q;
    logic par_err_q;
    logic [3:0] snap_q;
    logic armed_q;
    logic [7:0] cr1_q;
    logic [7:0] cr2_q;
    logic [2:0] lc_q;
    logic sfs_q;
    logic hdf_q;
    logic [7:0] data_q;
    logic rx8_q;
    logic irq_q;
    lsef_hdr_st_t hs_q;
    lsef_hdr_st_t hs_d;

    // ============================================================
    // bus handshake: one wait cycle per access
    wire req = AVS_READ_I || AVS_WRITE_I;
    wire acc = req && ack_q;
    wire rd_acc = AVS_READ_I && ack_q;
    wire wr_acc = AVS_WRITE_I && ack_q && AVS_BYTEENABLE_I[0];
    wire [7:0] wd = AVS_WRITEDATA_I[7:0];
    assign AVS_WAITREQUEST_O = req && !ack_q;
    assign AVS_READDATA_O = rdata_q;

    wire sel_sr = (AVS_ADDRESS_I == `LSEF_OFF_STATUS);
    wire sel_c1 = (AVS_ADDRESS_I == `LSEF_OFF_CTRL1);
    wire sel_c2 = (AVS_ADDRESS_I == `LSEF_OFF_CTRL2);
    wire sel_dr = (AVS_ADDRESS_I == `LSEF_OFF_DATA);
    wire sel_lc = (AVS_ADDRESS_I == `LSEF_OFF_LINCTL);

    wire sr_acc = acc && sel_sr;
    wire dr_rd = rd_acc && sel_dr;
    wire dr_acc = acc && sel_dr;
    wire c1_wr = wr_acc && sel_c1;
    wire c2_wr = wr_acc && sel_c2;
    wire lc_wr = wr_acc && sel_lc;

    // ============================================================
    // control decode
    wire lin = lc_q[`LSEF_LC_LIN];
    wire slv = lin && lc_q[`LSEF_LC_SLV];
    wire hdm = lc_q[`LSEF_LC_HDM];
    wire par_chk_en = cr1_q[`LSEF_CR1_PAR_CHK];
    wire par_irq_en = cr1_q[`LSEF_CR1_PAR_IRQ];
    wire rx_irq_en = cr2_q[`LSEF_CR2_RX_IRQ];
    wire rx_en = cr2_q[`LSEF_CR2_RE];

    assign TX_PAR_GEN_O = par_chk_en && !lin;
    assign PAR_ODD_O = cr1_q[`LSEF_CR1_PS] && !lin;

    // ============================================================
    // read mux
    wire [7:0] sr_val = {hi_q, hdr_err_q, noise_q, frm_err_q, par_err_q};
    wire [7:0] c1_val = {rx8_q, cr1_q[6:0]};
    wire [7:0] lc_val = {3'h0, hdf_q, sfs_q, lc_q};
    wire [7:0] rd_mux = sel_sr ? sr_val :
                        sel_c1 ? c1_val :
                        sel_c2 ? cr2_q :
                        sel_dr ? data_q :
                        sel_lc ? lc_val : 8'h00;

    // ============================================================
    // header phase and timeout
    wire tmo;
    wire brk = lin && RX_EVT_I.brk;
    wire in_hdr = (hs_q != HS_IDLE);
    wire tmr_run = (hs_q == HS_IDENT) || (hs_q == HS_SYNC && !sfs_q);
    wire sync_bad = (hs_q == HS_SYNC) && RX_EVT_I.synch_bad;

    lsef_hdr_timer #(
        .MAX_CYC(HDR_MAX_CYC)
    ) u_tmr (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .start_i(brk),
        .run_i(tmr_run),
        .expire_o(tmo)
    );

    always_comb begin
        hs_d = hs_q;
        unique case (hs_q)
            HS_IDLE: begin
                if (brk) begin
                    hs_d = HS_SYNC;
                end
            end
            HS_SYNC: begin
                if (brk) begin
                    hs_d = HS_SYNC;
                end else if (sfs_q && !lc_q[`LSEF_LC_LIN]) begin
                    hs_d = HS_IDLE;
                end else if (sfs_q) begin
                    hs_d = HS_SYNC;
                end else if (tmo) begin
                    hs_d = HS_IDLE;
                end else if (RX_EVT_I.synch_ok && !RX_EVT_I.synch_bad) begin
                    hs_d = HS_IDENT;
                end
            end
            HS_IDENT: begin
                if (brk) begin
                    hs_d = HS_SYNC;
                end else if (tmo || RX_EVT_I.id_done) begin
                    hs_d = HS_IDLE;
                end
            end
        endcase
    end

    // ============================================================
    // flag set terms
    wire [1:0] id_exp = id_par(RX_EVT_I.data[5:0]);
    wire id_bad = (RX_EVT_I.data[7:6] != id_exp);
    wire set_hdr_err = (lin && sync_bad)
                     || (lin && tmo)
                     || RX_EVT_I.overrun;
    wire set_noise = RX_EVT_I.char_done && RX_EVT_I.noise && !slv;
    wire frm_hit = RX_EVT_I.char_done && !RX_EVT_I.stop_bit;
    wire set_frm_err = frm_hit && (!slv || (RX_EVT_I.data != 8'h00));
    wire set_hdf = slv && ((brk && !hdm) || (RX_EVT_I.id_done && hdm));
    wire set_par_err = lin && par_chk_en && rx_en && in_hdr && RX_EVT_I.id_done && id_bad;
    wire set_sfs = lin && sync_bad;

    // ============================================================
    // two-step clear of status flags; synch lock and header detect clear on a lin control write that puts 0 in their bit
    wire clr_hdr_err = armed_q && dr_rd && snap_q[`LSEF_SR_HDR_ERR] && !sfs_q;
    wire clr_noise = armed_q && dr_rd && snap_q[`LSEF_SR_NOISE];
    wire clr_frm_err = armed_q && dr_rd && snap_q[`LSEF_SR_FRM_ERR];
    wire clr_par_err = armed_q && dr_acc && snap_q[`LSEF_SR_PAR_ERR];
    wire clr_sfs = lc_wr && !wd[`LSEF_LC_SFS];
    wire clr_hdf = lc_wr && !wd[`LSEF_LC_HDF];

    wire irq_d = (hdr_err_q && rx_irq_en) || (par_err_q && par_irq_en);

    // ============================================================
    // bus registers
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) begin
                rdata_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ============================================================
    // control registers
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            cr1_q <= `LSEF_CR1_RST;
            cr2_q <= `LSEF_CR2_RST;
            lc_q <= 3'h0;
        end else begin
            if (c1_wr) begin
                cr1_q <= wd;
            end
            if (c2_wr) begin
                cr2_q <= wd;
            end
            if (lc_wr) begin
                lc_q <= wd[2:0];
            end
        end
    end

    // ============================================================
    // receive data, status high bits, header state
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            data_q <= 8'h00;
            rx8_q <= 1'b0;
            hi_q <= 4'hc;
            hs_q <= HS_IDLE;
            irq_q <= 1'b0;
        end else begin
            if (RX_EVT_I.char_done) begin
                data_q <= RX_EVT_I.data;
                rx8_q <= RX_EVT_I.bit8;
            end
            hi_q <= TX_STAT_I;
            hs_q <= hs_d;
            irq_q <= irq_d;
        end
    end
    assign IRQ_O = irq_q;

    // ============================================================
    // flags: a set wins over a clear
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            hdr_err_q <= 1'b0;
            noise_q <= 1'b0;
            frm_err_q <= 1'b0;
            par_err_q <= 1'b0;
            sfs_q <= 1'b0;
            hdf_q <= 1'b0;
        end else begin
            hdr_err_q <= set_hdr_err || (hdr_err_q && !clr_hdr_err);
            noise_q <= set_noise || (noise_q && !clr_noise);
            frm_err_q <= set_frm_err || (frm_err_q && !clr_frm_err);
            par_err_q <= set_par_err || (par_err_q && !clr_par_err);
            sfs_q <= set_sfs || (sfs_q && !clr_sfs);
            hdf_q <= set_hdf || (hdf_q && !clr_hdf);
        end
    end

    // ============================================================
    // clear sequence arming
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            armed_q <= 1'b0;
            snap_q <= 4'h0;
        end else if (sr_acc) begin
            armed_q <= 1'b1;
            snap_q <= {hdr_err_q, noise_q, frm_err_q, par_err_q};
        end else if (dr_acc) begin
            armed_q <= 1'b0;
            snap_q <= 4'h0;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    a_hdr_sync_lock: assert property (sync_bad && lin |=> hdr_err_q && sfs_q)
        else $error("synch error did not set header error and lock");
    a_hdr_timeout: assert property (tmo |=> hdr_err_q && hs_q == HS_IDLE)
        else $error("header timeout did not set header error");
    a_hdr_overrun: assert property (RX_EVT_I.overrun |=> hdr_err_q)
        else $error("overrun did not set header error");
    a_irq_rx_hdr: assert property (hdr_err_q && rx_irq_en |-> ##1 IRQ_O)
        else $error("header error irq missing");
    a_irq_par_err: assert property (par_err_q && par_irq_en |-> ##1 IRQ_O)
        else $error("parity error irq missing");
    a_hdr_hold_lock: assert property ($fell(hdr_err_q) |-> !$past(sfs_q))
        else $error("header error cleared while synch state locked");
    a_hdr_clear_seq: assert property ($fell(hdr_err_q) |-> $past(armed_q && dr_rd))
        else $error("header error cleared outside sequence");
    a_noise_master: assert property (RX_EVT_I.char_done && RX_EVT_I.noise && !slv |=> noise_q)
        else $error("noise flag not set in master role");
    a_frm_break: assert property (slv && frm_hit && RX_EVT_I.data == 8'h00 && !frm_err_q |=> !frm_err_q)
        else $error("slave break set framing error");
    a_frm_real: assert property (slv && frm_hit && RX_EVT_I.data != 8'h00 |=> frm_err_q)
        else $error("slave real framing error missed");
    a_frm_clear_seq: assert property ($fell(frm_err_q) |-> $past(armed_q && dr_rd))
        else $error("framing error cleared outside sequence");
    a_par_set: assert property (set_par_err |=> par_err_q ##1 (par_err_q || $past(clr_par_err)))
        else $error("parity error not set");
    a_par_clear_seq: assert property ($fell(par_err_q) |-> $past(armed_q && dr_acc))
        else $error("parity error cleared outside sequence");
    a_no_lin_pargen: assert property (lin |-> !TX_PAR_GEN_O && !PAR_ODD_O)
        else $error("parity generation active in lin mode");
    a_bus_wait: assert property (req && !ack_q |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("waitrequest sequence broken");

    c_hdr_cleared: cover property (armed_q && dr_rd && hdr_err_q ##1 !hdr_err_q);
    c_par_set: cover property (set_par_err);
    c_frm_set: cover property (set_frm_err);
    c_hdr_timeout: cover property (tmo);
    c_sync_lock: cover property (sfs_q ##1 !sfs_q);

endmodule : lsef_flags

`default_nettype wire

// ==== sim/lsef_lin_node.sv ====
/*
 * model of the other nodes on the lin bus: it turns bench commands into
 * receiver event pulses.
 * assumes: commands are synchronous to clk_i and last one cycle.
 */
`default_nettype none

module lsef_lin_node
    import lsef_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic go_i,
    input wire logic [2:0] kind_i,
    input wire logic [7:0] byte_i,
    input wire logic stop_i,
    output var lsef_rx_evt_t evt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] last_q;
    lsef_rx_evt_t nxt;

    // ============================================================
    // event pulses; data lines show a changing pattern when idle
    always_comb begin
        nxt = '0;
        nxt.data = go_i ? byte_i : ~last_q;
        nxt.stop_bit = go_i ? stop_i : ~last_q[0];
        if (go_i) begin
            case (kind_i)
                3'h0: nxt.brk = 1'b1;
                3'h1: nxt.synch_ok = 1'b1;
                3'h2: nxt.synch_bad = 1'b1;
                3'h3: nxt.char_done = 1'b1;
                3'h4: nxt.overrun = 1'b1;
                3'h5: nxt.id_done = 1'b1;
                default: begin
                    // noise is reported with a received character
                    nxt.char_done = 1'b1;
                    nxt.noise = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            last_q <= 8'h00;
            evt_o <= '0;
        end else begin
            last_q <= go_i ? byte_i : ~last_q;
            evt_o <= nxt;
        end
    end
endmodule : lsef_lin_node

`default_nettype wire

// ==== sim/testbench.sv ====
/*
 * self-checking bench of the lin status and error flag block.
 * assumes: avalon-mm slave with one wait cycle; partner model drives events.
 */
`default_nettype none
`include "lsef_consts.svh"

module testbench
    import lsef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HDR = 50;
    localparam logic [7:0] SR = `LSEF_OFF_STATUS;
    localparam logic [7:0] DR = `LSEF_OFF_DATA;
    localparam logic [7:0] LC = `LSEF_OFF_LINCTL;
    localparam logic [7:0] C1 = `LSEF_OFF_CTRL1;
    localparam logic [7:0] C2 = `LSEF_OFF_CTRL2;

    logic clk, nrst, rd_en, wr_en, go, stp, irq, par_odd, par_gen, wreq;
    logic [7:0] addr, byt, rv;
    logic [2:0] kind;
    logic [31:0] wdat, rdat;
    lsef_rx_evt_t evt;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;

    lsef_flags #(.HDR_MAX_CYC(HDR)) u_lsef_flags (
        .CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq), .RX_EVT_I(evt),
        .TX_STAT_I(4'hc), .IRQ_O(irq), .PAR_ODD_O(par_odd), .TX_PAR_GEN_O(par_gen)
    );

    lsef_lin_node u_lsef_lin_node (
        .clk_i(clk), .nrst_i(nrst), .go_i(go), .kind_i(kind), .byte_i(byt),
        .stop_i(stp), .evt_o(evt)
    );

    // ============================================================
    // clock and timeout
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ============================================================
    // tasks
    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdat <= {24'h0, d};
        rd_en <= !we;
        wr_en <= we;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        rv = rdat[7:0];
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        bus(1'b0, a, 8'h00);
        chk(rv & m, exp);
    endtask : rdc

    task automatic clr(input logic wr_data);
        bus(1'b0, SR, 8'h00);
        bus(wr_data, DR, 8'h00);
    endtask : clr

    task automatic ev(input logic [2:0] k, input logic [7:0] b = 8'h00, input logic s = 1'b1);
        go <= 1'b1;
        kind <= k;
        byt <= b;
        stp <= s;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : ev

    function automatic logic [7:0] idb(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction : idb

    // ============================================================
    // main sequence; kinds: 0 brk 1 sync ok 2 sync bad 3 char 4 overrun 5 id 6 noise
    initial begin
        nrst = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 8'h00;
        wdat = 32'h0;
        go = 1'b0;
        kind = 3'h0;
        byt = 8'h00;
        stp = 1'b1;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(SR, 8'hc0);
        rdc(C1, 8'h00);
        bus(1'b1, SR, 8'h0f);
        rdc(SR, 8'hc0);
        rdc(8'h14, 8'h00);
        bus(1'b1, C1, 8'hff);
        rdc(C1, 8'h7f);
        chk({7'h0, par_gen}, 8'h01);
        chk({7'h0, par_odd}, 8'h01);
        bus(1'b1, LC, 8'h01);
        bus(1'b1, C2, 8'h24);
        bus(1'b1, C1, 8'h07);
        chk({7'h0, par_gen}, 8'h00);
        chk({7'h0, par_odd}, 8'h00);
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, C1, (j == 2) ? 8'h01 : 8'h05);
            ev(3'h0);
            ev(3'h1);
            ev(3'h5, idb(6'h2a) ^ ((j > 0) ? 8'h40 : 8'h00));
            rdc(SR, (j == 1) ? 8'hc1 : 8'hc0);
            if (j == 1) chk({7'h0, irq}, 8'h01);
            clr(1'b1);
            rdc(SR, 8'hc0);
        end
        ev(3'h6);
        rdc(SR, 8'hc4);
        clr(1'b0);
        rdc(SR, 8'hc0);
        bus(1'b0, SR, 8'h00);
        ev(3'h6);
        bus(1'b0, DR, 8'h00);
        rdc(SR, 8'hc4);
        clr(1'b0);
        rdc(SR, 8'hc0);
        for (int j = 0; j < 2; j++) begin
            if (j == 0) ev(3'h0);
            if (j == 0) ev(3'h1);
            ev(3'h4);
            if (j == 0) ev(3'h5, idb(6'h05));
            rdc(SR, 8'hc8);
            clr(1'b0);
            rdc(SR, 8'hc0);
        end
        ev(3'h0);
        ev(3'h1);
        repeat (HDR + 10) @(posedge clk);
        rdc(SR, 8'hc8);
        clr(1'b0);
        rdc(SR, 8'hc0);
        ev(3'h0);
        ev(3'h2);
        rdc(SR, 8'hc8);
        rdc(LC, 8'h08, 8'h08);
        chk({7'h0, irq}, 8'h01);
        bus(1'b1, C2, 8'h04);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        clr(1'b0);
        rdc(SR, 8'hc8);
        bus(1'b1, LC, 8'h01);
        repeat (HDR + 10) @(posedge clk);
        clr(1'b0);
        rdc(SR, 8'hc0);
        bus(1'b1, C2, 8'h24);
        bus(1'b1, LC, 8'h03);
        ev(3'h0);
        rdc(LC, 8'h10, 8'h10);
        ev(3'h1);
        ev(3'h5, idb(6'h11));
        ev(3'h3, 8'h00, 1'b0);
        rdc(SR, 8'hc0, 8'hfb);
        ev(3'h3, 8'h55, 1'b1);
        rdc(SR, 8'hc0, 8'hfb);
        ev(3'h3, 8'h55, 1'b0);
        rdc(SR, 8'hc2, 8'hfb);
        clr(1'b0);
        rdc(SR, 8'hc0, 8'hfb);
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
